//--- hdl/chg_pins_pkg.sv
// shared constants and types of the charger control-pin block
// assumes a 50 MHz core clock and a 32-bit avalon-mm register port
package chg_pins_pkg;

   // clock and timing
   localparam int unsigned CLK_HZ        = 50000000;
   localparam longint unsigned LONG_TMR_S = 900;   // 15 min safety timer
   localparam longint unsigned SHORT_TMR_S = 32;   // 32 s safety timer
   localparam longint unsigned LONG_TMR_CYC  = LONG_TMR_S * CLK_HZ;
   localparam longint unsigned SHORT_TMR_CYC = SHORT_TMR_S * CLK_HZ;
   localparam int unsigned FAULT_PULSE_NS = 128000; // 128 us
   localparam int unsigned FAULT_PULSE_CYC = FAULT_PULSE_NS / 20;
   localparam int unsigned LED_TICK_NS    = 1000000; // 1 ms blink unit
   localparam int unsigned LED_TICK_CYC   = LED_TICK_NS / 20;

   // register byte offsets
   localparam logic [3:0] OFS_CTRL   = 4'h0;
   localparam logic [3:0] OFS_SAFETY = 4'h4;
   localparam logic [3:0] OFS_LED    = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'hC;

   // control register fields
   localparam int CTL_BOOST_SW = 0;  // software boost request
   localparam int CTL_PIN_EN   = 1;  // boost pin enable
   localparam int CTL_PIN_POL  = 2;  // 1: pin active high
   localparam int CTL_STAT_EN  = 3;  // status output enable
   localparam int CTL_LONG_TMR = 4;  // 1: 15 min timer, 0: 32 s
   localparam int CTL_ILIM_500 = 5;  // software input limit select
   localparam logic [5:0] CTRL_RST = 6'h0E;

   // safety limit register
   localparam logic [7:0] SAFETY_DEF = 8'h00;

   // led register fields: current [3:0], on [15:8], off [23:16]
   localparam int LED_ON_LSB  = 8;
   localparam int LED_OFF_LSB = 16;

   // synchronised pin bundle
   typedef struct packed {
      logic unlock;
      logic chg_off;
      logic boost;
   } pins_t;

   typedef enum logic [1:0] {
      LED_IDLE = 2'b00,
      LED_ON   = 2'b01,
      LED_OFF  = 2'b10
   } led_state_t;

endpackage : chg_pins_pkg

//--- hdl/charger_control_pin_logic.sv
// control-pin logic of a switch-mode charger: safety limit lock, charge
// disable, boost request pin, open-drain status output, indicator timing
// assumes charge_active and fault_event come from logic on mclk;
// pins arrive asynchronously and are synchronised here
//
// Contract
// [RULE1] unlock low: safety limit held at default, writes to it ignored
// [RULE2] unlock high: limit writable until first write to another register
// [RULE3] charge enabled when disable pin low, disabled when high
// [RULE4] disabled charging puts both supply inputs in high impedance
// [RULE5] long timer mode: disable pin high resets the 15 min timer
// [RULE6] short timer mode: disable pin high leaves 32 s timer counting
// [RULE7] active boost pin forces bus converter into boost
// [RULE8] boost pin overrides software boost; software may disable the pin
// [RULE9] control bit selects active level of the boost pin
// [RULE10] after reset the pin only selects input current limit
// [RULE11] in that role pin high gives 500 mA, low gives 100 mA
// [RULE12] status pulls low while charging, open otherwise
// [RULE13] a fault sends one 128 us pulse on the status output
// [RULE14] status output disabled while its enable bit is clear
// [RULE15] indicator current, on and off time come from a register
// [RULE16] lock stays until unlock goes low or reset
// [RULE17] disable, unlock and boost pins synchronised before use
//
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
module charger_control_pin_logic
   import chg_pins_pkg::*;
#(
   parameter longint unsigned LONG_CYC  = LONG_TMR_CYC,
   parameter longint unsigned SHORT_CYC = SHORT_TMR_CYC,
   parameter int unsigned     FAULT_CYC = FAULT_PULSE_CYC,
   parameter int unsigned     TICK_CYC  = LED_TICK_CYC
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // avalon-mm slave
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output var  logic [31:0] readdata,
   output var  logic        waitrequest,
   // asynchronous pins
   input  wire logic        safety_limit_unlock,
   input  wire logic        charge_disable_pin,
   input  wire logic        boost_request_pin,
   // analog-side events on mclk
   input  wire logic        charge_active,
   input  wire logic        fault_event,
   // control outputs
   output var  logic        charge_enable,
   output var  logic        supply_hiz,
   output var  logic        boost_mode,
   output var  logic        input_current_limit,
   output var  logic        timer_expired,
   output var  logic [7:0]  safety_limit,
   // open-drain status pin
   output var  logic        stat_o,
   output var  logic        stat_oe,
   // indicator driver
   output var  logic [3:0]  led_current
);

   pins_t      meta_q;
   pins_t      pin_q;
   logic [5:0] ctrl_q;
   logic [7:0] safety_q;
   logic [23:0] led_q;
   logic       locked_q;
   logic       por_role_q;
   logic       wr_acc;
   pins_t      pin_raw;
   logic [35:0] tmr_q;
   logic [12:0] fault_cnt_q;
   logic       fault_d1_q;
   logic [15:0] tick_q;
   logic [7:0] phase_q;
   led_state_t led_st_q;
   logic       pin_hit;

   // [RULE17] two-stage synchroniser
   // first stage feeds only the second
   assign pin_raw = {safety_limit_unlock, charge_disable_pin, boost_request_pin};
   for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge mclk) begin
         if (!rst_n) begin
            meta_q[i] <= 1'b0;
            pin_q[i]  <= 1'b0;
         end else begin
            meta_q[i] <= pin_raw[i];
            pin_q[i]  <= meta_q[i];
         end
      end
   end

   // bus handshake: one wait cycle, then the access completes
   assign wr_acc = write && !waitrequest;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !((read || write) && waitrequest);
      end
   end

   // read data latched in the wait cycle so it stands at the done edge
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         readdata <= 32'h0000_0000;
      end else if (read && waitrequest) begin
         unique case (address)
            OFS_CTRL:   readdata <= {26'h0, ctrl_q};
            OFS_SAFETY: readdata <= {24'h00, safety_q};
            OFS_LED:    readdata <= {8'h00, led_q};
            OFS_STATUS: readdata <= {26'h0, timer_expired, por_role_q,
                                     locked_q, input_current_limit,
                                     boost_mode, charge_enable};
            default:    readdata <= 32'h0000_0000;
         endcase
      end
   end

   // control and indicator registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl_q <= CTRL_RST;
         led_q  <= 24'h00_0000;
      end else if (wr_acc) begin
         if (address == OFS_CTRL) begin
            ctrl_q <= writedata[5:0];
         end
         if (address == OFS_LED) begin
            led_q <= writedata[23:0];
         end
      end
   end

   // [RULE1] default while unlock is low
   // [RULE2] writes accepted only while unlocked
   always_ff @(posedge mclk) begin
      if (!rst_n || !pin_q.unlock) begin
         safety_q <= SAFETY_DEF;
      end else if (wr_acc && address == OFS_SAFETY && !locked_q) begin
         safety_q <= writedata[7:0];
      end
   end

   // [RULE16] lock set by another write, cleared by unlock low
   always_ff @(posedge mclk) begin
      if (!rst_n || !pin_q.unlock) begin
         locked_q <= 1'b0;
      end else if (wr_acc && address != OFS_SAFETY) begin
         locked_q <= 1'b1;
      end
   end

   // [RULE10] power-on role ends at first control write
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         por_role_q <= 1'b1;
      end else if (wr_acc && address == OFS_CTRL) begin
         por_role_q <= 1'b0;
      end
   end

   // [RULE9] configured polarity
   assign pin_hit = ctrl_q[CTL_PIN_EN] && (pin_q.boost == ctrl_q[CTL_PIN_POL]);

   // converter outputs registered from synchronised state
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         charge_enable       <= 1'b0;
         supply_hiz          <= 1'b1;
         boost_mode          <= 1'b0;
         input_current_limit <= 1'b0;
         safety_limit        <= SAFETY_DEF;
      end else begin
         // [RULE3] enable from pin level
         charge_enable <= !pin_q.chg_off;
         // [RULE4] supply inputs released
         supply_hiz    <= pin_q.chg_off;
         safety_limit  <= safety_q;
         if (por_role_q) begin
            // [RULE11] pin picks 500 or 100 mA
            input_current_limit <= pin_q.boost;
            boost_mode          <= ctrl_q[CTL_BOOST_SW];
         end else begin
            input_current_limit <= ctrl_q[CTL_ILIM_500];
            // [RULE7] pin forces boost
            // [RULE8] enabled pin overrides software
            boost_mode <= ctrl_q[CTL_PIN_EN] ? pin_hit : ctrl_q[CTL_BOOST_SW];
         end
      end
   end

   // safety timer; short mode keeps counting through a disable
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tmr_q         <= 36'h0_0000_0000;
         timer_expired <= 1'b0;
      end else if (ctrl_q[CTL_LONG_TMR] && pin_q.chg_off) begin
         // [RULE5] long timer restarts
         tmr_q         <= 36'h0_0000_0000;
         timer_expired <= 1'b0;
      end else if (!timer_expired) begin
         // [RULE6] short timer keeps counting
         tmr_q <= tmr_q + 36'h1;
         if (tmr_q + 36'h1 >= 36'(ctrl_q[CTL_LONG_TMR] ? LONG_CYC : SHORT_CYC)) begin
            timer_expired <= 1'b1;
         end
      end
   end

   // [RULE13] one pulse per fault edge; a new edge restarts it
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         fault_d1_q  <= 1'b0;
         fault_cnt_q <= 13'h0000;
      end else begin
         fault_d1_q <= fault_event;
         if (fault_event && !fault_d1_q) begin
            fault_cnt_q <= 13'(FAULT_CYC);
         end else if (fault_cnt_q != 13'h0000) begin
            fault_cnt_q <= fault_cnt_q - 13'h1;
         end
      end
   end

   // status pin; pulse drives low, output data is always zero
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         stat_o  <= 1'b0;
         stat_oe <= 1'b0;
      end else begin
         stat_o <= 1'b0;
         // [RULE14] enable bit gates the pin
         // [RULE12] low while charging
         stat_oe <= ctrl_q[CTL_STAT_EN] &&
                    ((fault_cnt_q != 13'h0000) || (charge_active && !pin_q.chg_off));
      end
   end

   // indicator tick; a coarse unit keeps the phase counters short
   always_ff @(posedge mclk) begin
      if (!rst_n || tick_q == 16'(TICK_CYC - 1)) begin
         tick_q <= 16'h0000;
      end else begin
         tick_q <= tick_q + 16'h1;
      end
   end

   // [RULE15] blink from programmed current, on and off times
   // zero on time keeps it dark, zero off time keeps it lit
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         led_st_q    <= LED_IDLE;
         phase_q     <= 8'h00;
         led_current <= 4'h0;
      end else begin
         unique case (led_st_q)
            LED_IDLE: begin
               led_current <= 4'h0;
               if (led_q[LED_ON_LSB +: 8] != 8'h00) begin
                  led_st_q <= LED_ON;
                  phase_q  <= led_q[LED_ON_LSB +: 8];
               end
            end
            LED_ON: begin
               led_current <= led_q[3:0];
               if (led_q[LED_ON_LSB +: 8] == 8'h00) begin
                  led_st_q <= LED_IDLE;
               end else if (tick_q == 16'h0000) begin
                  if (phase_q > 8'h01) begin
                     phase_q <= phase_q - 8'h1;
                  end else if (led_q[LED_OFF_LSB +: 8] != 8'h00) begin
                     led_st_q <= LED_OFF;
                     phase_q  <= led_q[LED_OFF_LSB +: 8];
                  end else begin
                     phase_q <= led_q[LED_ON_LSB +: 8];
                  end
               end
            end
            LED_OFF: begin
               led_current <= 4'h0;
               if (tick_q == 16'h0000) begin
                  if (phase_q > 8'h01) begin
                     phase_q <= phase_q - 8'h1;
                  end else if (led_q[LED_ON_LSB +: 8] != 8'h00) begin
                     led_st_q <= LED_ON; // no idle pass, on time stays exact
                     phase_q  <= led_q[LED_ON_LSB +: 8];
                  end else begin
                     led_st_q <= LED_IDLE;
                  end
               end
            end
            default: begin
               led_st_q <= LED_IDLE;
            end
         endcase
      end
   end

   // checks on the behaviour above
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_fault_edge;
      fault_event && !fault_d1_q;
   endsequence

   sequence s_pulse_run;
      fault_cnt_q != 13'h0000;
   endsequence

   a_limit_default: assert property ( // RULE1
      !pin_q.unlock |=> safety_q == SAFETY_DEF)
      else $error("safety limit left default while locked out");

   a_limit_lock_hold: assert property ( // RULE2
      locked_q && pin_q.unlock |=> $stable(safety_q))
      else $error("safety limit changed after lock");

   a_lock_cause: assert property ( // RULE2
      locked_q && $past(pin_q.unlock) && pin_q.unlock && !$past(locked_q) |-> 1'b1 ##0
      $past(wr_acc) && $past(address) != OFS_SAFETY)
      else $error("lock set without a foreign write");

   a_lock_stays: assert property ( // RULE16
      locked_q && pin_q.unlock |=> locked_q)
      else $error("lock dropped while unlock high");

   a_charge_follow: assert property ( // RULE3
      pin_q.chg_off |=> !charge_enable && supply_hiz)
      else $error("charge not disabled by pin");

   a_sync_delay: assert property ( // RULE17
      $rose(charge_disable_pin) ##1 charge_disable_pin |=> pin_q.chg_off)
      else $error("disable pin not synchronised in time");

   a_long_reset: assert property ( // RULE5
      ctrl_q[CTL_LONG_TMR] && pin_q.chg_off |=> tmr_q == 36'h0)
      else $error("long timer not reset by disable");

   a_short_count: assert property ( // RULE6
      !ctrl_q[CTL_LONG_TMR] && !timer_expired && $past(rst_n) |=>
      tmr_q == $past(tmr_q) + 36'h1)
      else $error("short timer stopped");

   a_boost_prio: assert property ( // RULE8
      !por_role_q && ctrl_q[CTL_PIN_EN] && $stable(ctrl_q) |=> boost_mode == $past(pin_hit))
      else $error("boost pin lost priority");

   a_ilim_por: assert property ( // RULE11
      por_role_q |=> input_current_limit == $past(pin_q.boost))
      else $error("power-on current limit select wrong");

   a_stat_off: assert property ( // RULE14
      !ctrl_q[CTL_STAT_EN] |=> !stat_oe)
      else $error("status driven while disabled");

   a_fault_pulse: assert property ( // RULE13
      s_fault_edge |=> s_pulse_run ##1 (fault_cnt_q == 13'(FAULT_CYC - 1) || $rose(fault_event)))
      else $error("fault pulse count wrong");

endmodule : charger_control_pin_logic
`default_nettype wire

//--- sim/host_pins_model.sv
// host-side model: drives the three control pins and resolves the status wire
// assumes the bench asks for pin levels on mclk and reads the resolved wire
`timescale 1ns/1ps
`default_nettype none
module host_pins_model (
   // clock
   input  wire logic mclk,
   // wanted levels from the bench
   input  wire logic want_unlock,
   input  wire logic want_off,
   input  wire logic want_boost,
   // pins toward the device
   output var  logic safety_limit_unlock,
   output var  logic charge_disable_pin,
   output var  logic boost_request_pin,
   // open-drain status pin
   input  wire logic stat_o,
   input  wire logic stat_oe,
   output var  logic stat_line
);
   // unlock, disable and boost pin drive
   // pins move one clock after the request, like a polled gpio port,
   // so the device always sees them off its own sampling edge
   always_ff @(posedge mclk) begin
      safety_limit_unlock <= want_unlock;
      charge_disable_pin  <= want_off;
      boost_request_pin   <= want_boost;
   end

   // pull-up keeps the wire high unless the device sinks it
   assign stat_line = stat_oe ? stat_o : 1'b1;
endmodule : host_pins_model
`default_nettype wire

//--- sim/tb.sv
// self-checking bench for the charger control-pin block
// assumes the host model owns the pins; counts are shortened by parameters
`timescale 1ns/1ps
`default_nettype none
module tb
   import chg_pins_pkg::*;
;
   localparam int LCYC = 200, SCYC = 100, FCYC = 20, TCYC = 4, TMO = 4000;
   logic        mclk, rst_n, read, write, w_unl, w_off, w_bst;
   logic        charge_active, fault_event, waitrequest, stat_o, stat_oe;
   logic        charge_enable, supply_hiz, boost_mode, input_current_limit;
   logic        timer_expired, stat_line, unl_pin, off_pin, bst_pin;
   logic [3:0]  address, led_current;
   logic [31:0] writedata, readdata, q;
   logic [7:0]  safety_limit, r;
   int          fails = 0, cmp_count = 0, tcnt = 0, n;

   charger_control_pin_logic #(.LONG_CYC(LCYC), .SHORT_CYC(SCYC), .FAULT_CYC(FCYC),
      .TICK_CYC(TCYC)) u_charger_control_pin_logic (.mclk, .rst_n, .address, .read,
      .write, .writedata, .readdata, .waitrequest, .safety_limit_unlock(unl_pin),
      .charge_disable_pin(off_pin), .boost_request_pin(bst_pin), .charge_active,
      .fault_event, .charge_enable, .supply_hiz, .boost_mode, .input_current_limit,
      .timer_expired, .safety_limit, .stat_o, .stat_oe, .led_current);

   host_pins_model u_host_pins_model (.mclk, .want_unlock(w_unl), .want_off(w_off),
      .want_boost(w_bst), .safety_limit_unlock(unl_pin), .charge_disable_pin(off_pin),
      .boost_request_pin(bst_pin), .stat_o, .stat_oe, .stat_line);

   // 50 MHz clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // hang guard: a run past the ceiling counts as a mismatch
   always @(posedge mclk) begin
      tcnt++;
      if (tcnt == TMO) begin
         chk(32'h1, 32'h0);
         stop_test();
      end
   end

   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
   endtask : cyc

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one avalon access; the extra edge at the end keeps strobes from
   // being lowered and raised in the same time step
   // only the hang guard ends a wait for an answer that never comes
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      address   <= a;
      writedata <= d;
      write     <= w;
      read      <= !w;
      do begin
         @(posedge mclk);
      end while (waitrequest !== 1'b0);
      q = readdata;
      write <= 1'b0;
      read  <= 1'b0;
      @(posedge mclk);
   endtask : bus

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask : rdc

   // count cycles the indicator stays at one level
   task automatic run(input logic [3:0] v);
      n = 0;
      while (led_current === v && n < 200) begin
         cyc(1);
         n++;
      end
   endtask : run

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done

   // c = {polarity, pin enable, software boost}
   function automatic logic exp_boost(input logic [2:0] c, input logic pin);
      if (c[1]) return pin == c[2];
      return c[0];
   endfunction : exp_boost

   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test

   // main sequence
   initial begin
      {rst_n, read, write, w_unl, w_off, w_bst, charge_active, fault_event} = '0;
      address = '0;
      writedata = '0;
      void'($urandom(57));
      cyc(8);
      rst_n <= 1'b1;
      cyc(2);
      rdc(OFS_CTRL, 32'(CTRL_RST));
      rdc(4'h2, 32'h0);
      for (int i = 0; i < 4; i++) begin
         w_bst <= i[0];
         cyc(6);
         chk(32'(input_current_limit), 32'(i[0]));
         chk(32'(boost_mode), 32'h0);
      end
      done("power_on");
      r = 8'($urandom_range(255, 1));
      wr(OFS_SAFETY, 32'(r));
      rdc(OFS_SAFETY, 32'h0);
      w_unl <= 1'b1;
      cyc(6);
      wr(OFS_SAFETY, 32'(r));
      rdc(OFS_SAFETY, 32'(r));
      chk(32'(safety_limit), 32'(r));
      wr(OFS_LED, 32'h0003_0205);
      wr(OFS_SAFETY, 32'(~r));
      rdc(OFS_SAFETY, 32'(r));
      w_unl <= 1'b0;
      cyc(6);
      chk(32'(safety_limit), 32'h0);
      done("safety");
      rdc(OFS_LED, 32'h0003_0205);
      run(4'h5);
      run(4'h0);
      run(4'h5);
      chk(32'(n), 32'(2 * TCYC));
      run(4'h0);
      chk(32'(n), 32'(3 * TCYC));
      done("indicator");
      for (int i = 0; i < 6; i++) begin
         r[1] = w_off;
         r[0] = 1'($urandom);
         w_off <= r[0];
         cyc(3);
         chk(32'(charge_enable), 32'(!r[1]));
         cyc(3);
         chk(32'(charge_enable), 32'(!r[0]));
         chk(32'(supply_hiz), 32'(r[0]));
      end
      w_off <= 1'b0;
      done("disable");
      for (int i = 0; i < 16; i++) begin
         r = 8'($urandom);
         wr(OFS_CTRL, {26'h0, r[5], 2'b01, i[2:0]});
         w_bst <= i[3];
         cyc(6);
         chk(32'(boost_mode), 32'(exp_boost(i[2:0], i[3])));
         chk(32'(input_current_limit), 32'(r[5]));
      end
      done("boost");
      charge_active <= 1'b1;
      wr(OFS_CTRL, 32'h08);
      cyc(4);
      chk(32'(stat_line), 32'h0);
      wr(OFS_CTRL, 32'h00);
      cyc(4);
      chk(32'(stat_line), 32'h1);
      charge_active <= 1'b0;
      wr(OFS_CTRL, 32'h08);
      cyc(4);
      chk(32'(stat_line), 32'h1);
      fault_event <= 1'b1;
      cyc(1);
      fault_event <= 1'b0;
      n = 0;
      repeat (FCYC + 20) begin
         cyc(1);
         if (stat_line === 1'b0) n++;
      end
      chk(32'(n), 32'(FCYC));
      done("status");
      // second reset in mid-run restarts the safety timer in short mode
      w_off <= 1'b1;
      charge_active <= 1'b1;
      rst_n <= 1'b0;
      cyc(3);
      rst_n <= 1'b1;
      cyc(SCYC + 20);
      chk(32'(timer_expired), 32'h1);
      wr(OFS_CTRL, 32'h18);
      cyc(10);
      chk(32'(timer_expired), 32'h0);
      cyc(LCYC + 20);
      chk(32'(timer_expired), 32'h0);
      w_off <= 1'b0;
      cyc(LCYC - 20);
      chk(32'(timer_expired), 32'h0);
      cyc(40);
      chk(32'(timer_expired), 32'h1);
      done("timer");
      stop_test();
   end
endmodule : tb
`default_nettype wire
